// File: nibble_alu.sv
// Four-bit arithmetic and logic unit for the execute block
module nibble_alu (
  input  wire nibble_exec_pkg::alu_op_t op_i,
  input  wire logic [3:0]               a_i,
  input  wire logic [3:0]               b_i,
  input  wire logic                     cin_i,
  output logic      [3:0]               res_o,
  output logic                          cout_o
);
  import nibble_exec_pkg::*;

  logic [4:0] wide;

  // Bit 4 is carry on add and borrow on subtract
  always_comb begin
    wide = 5'h00;
    case (op_i)
      ALU_ADD: wide = {1'b0, a_i} + {1'b0, b_i} + {4'h0, cin_i};
      ALU_SUB: wide = {1'b0, a_i} - {1'b0, b_i} - {4'h0, cin_i};
      ALU_OR:  wide = {1'b0, a_i | b_i};
      ALU_DEC: wide = {1'b0, a_i} - 5'h01;
      default: wide = {1'b0, a_i};
    endcase
  end

  assign res_o  = wide[3:0];
  assign cout_o = wide[4];

endmodule

// File: nibble_alu_branch_exec.sv
// Decode and execute of nibble arithmetic, OR, branch and skip instructions
`include "nibble_exec_defs.svh"

module nibble_alu_branch_exec #(
  parameter int AW = 7
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        instr_valid_i,
  output logic             instr_ready_o,
  output logic             done_o,
  output logic [13:0]      pc_o,
  output logic [3:0]       acc_o,
  output nibble_exec_pkg::flags_t flags_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  import nibble_exec_pkg::*;

  if (AW != 7) begin : g_check
    $error("nibble_alu_branch_exec supports a 7-bit data address only");
  end

  phase_t      phase_reg;
  phase_t      phase_next;
  logic [15:0] instr_reg;
  decode_t     dec;
  logic [13:0] pc_reg;
  logic [3:0]  acc_reg;
  flags_t      flags_reg;
  logic [2:0]  bank_reg;
  logic [2:0]  page_reg;
  logic        run_reg;
  logic        ready_reg;
  logic        done_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;

  logic [AW-1:0] mem_addr;
  logic [3:0]    mem_rdata;
  logic [3:0]    alu_b;
  logic [3:0]    alu_res;
  logic          alu_cout;
  logic          res_zero;
  logic          take_branch;
  logic          take_skip;
  logic          exec;
  logic          accept;
  logic [13:0]   pc_seq;
  logic [13:0]   pc_exec;

  logic          bus_req;
  logic          bus_wr;
  logic [5:0]    bus_idx;

  assign accept  = (phase_reg == PH_FETCH) && instr_valid_i && ready_reg;
  assign exec    = (phase_reg == PH_EXEC);
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_idx = wb_adr_i[7:2];
  // Writes land only at the edge where the master sees ack
  assign bus_wr  = bus_req && wb_we_i && ack_reg;

  // Machine cycle: fetch, read, execute, settle (four clocks)
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_FETCH:  phase_next = accept ? PH_READ : PH_FETCH;
      PH_READ:   phase_next = PH_EXEC;
      PH_EXEC:   phase_next = PH_SETTLE;
      PH_SETTLE: phase_next = PH_FETCH;
      default:   phase_next = PH_FETCH;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= PH_FETCH;
    end else if (ce_i) begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else if (ce_i) begin
      ready_reg <= (phase_next == PH_FETCH) && run_reg;
      done_reg  <= exec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_reg <= 16'h0000;
    end else if (ce_i && accept) begin
      instr_reg <= instr_i;
    end
  end

  // Decode of the instruction held for this machine cycle
  always_comb begin
    dec         = '0;
    dec.op      = ALU_PASS;
    dec.br      = BR_NONE;
    dec.sk      = SK_NONE;
    dec.use_imm = instr_reg[10];
    if (!instr_reg[11] && instr_reg[15:12] >= 4'h7) begin
      dec.bit_sel = instr_reg[13:12];
      case (instr_reg[15:12])
        4'h7:    dec.br = BR_JUMP;
        4'h8, 4'h9, 4'ha, 4'hb: dec.br = BR_ACC_BIT;
        4'hc:    dec.br = BR_NONZERO;
        4'hd:    dec.br = BR_NO_CARRY;
        4'he:    dec.br = BR_ZERO;
        4'hf:    dec.br = BR_CARRY;
        default: dec.br = BR_NONE;
      endcase
    end else begin
      case (instr_reg[15:8])
        8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f: begin
          dec.op      = instr_reg[9] ? ALU_SUB : ALU_ADD;
          dec.use_cin = 1'b1;
          dec.wr_acc  = instr_reg[10] || !instr_reg[7];
          dec.wr_mem  = dec.wr_acc && instr_reg[8];
          dec.upd_cf  = dec.wr_acc;
          dec.upd_zf  = dec.wr_acc;
        end
        8'h3a, 8'h3b, 8'h3e, 8'h3f: begin
          dec.op      = ALU_OR;
          dec.wr_acc  = instr_reg[10] || !instr_reg[7];
          dec.wr_mem  = dec.wr_acc && instr_reg[8];
          dec.upd_zf  = dec.wr_acc;
        end
        8'h48: begin
          dec.use_imm = 1'b0;
          dec.op      = ALU_DEC;
          dec.wr_acc  = 1'b1;
          dec.wr_mem  = 1'b1;
          dec.upd_cf  = 1'b1;
          dec.upd_zf  = 1'b1;
          dec.sk      = instr_reg[7] ? SK_NONZERO : SK_ZERO;
        end
        8'ha8, 8'ha9: begin
          dec.use_imm = 1'b0;
          dec.sk      = SK_MEM_BIT;
          dec.bit_sel = instr_reg[8:7];
        end
        default: dec.use_imm = 1'b0;
      endcase
    end
  end

  // Scratch nibbles sit in the page chosen by page_reg
  assign mem_addr = dec.use_imm ? {page_reg, instr_reg[3:0]}
                                : instr_reg[AW-1:0];

  nibble_data_mem #(
    .AW (AW),
    .DW (4)
  ) u_mem (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .raddr_i (mem_addr),
    .rdata_o (mem_rdata),
    .we_i    (exec && dec.wr_mem),
    .waddr_i (mem_addr),
    .wdata_i (alu_res)
  );

  // Immediate constant from bits 7..4, else the result register
  assign alu_b = dec.use_imm ? instr_reg[7:4] : acc_reg;

  nibble_alu u_alu (
    .op_i   (dec.op),
    .a_i    (mem_rdata),
    .b_i    (alu_b),
    .cin_i  (dec.use_cin && flags_reg.carry_bit),
    .res_o  (alu_res),
    .cout_o (alu_cout)
  );

  assign res_zero = (alu_res == 4'h0);

  always_comb begin
    take_branch = 1'b0;
    case (dec.br)
      BR_JUMP:     take_branch = 1'b1;
      BR_ACC_BIT:  take_branch = acc_reg[dec.bit_sel];
      BR_ZERO:     take_branch = (acc_reg == 4'h0);
      BR_NONZERO:  take_branch = (acc_reg != 4'h0);
      BR_CARRY:    take_branch = flags_reg.carry_bit;
      BR_NO_CARRY: take_branch = !flags_reg.carry_bit;
      default:     take_branch = 1'b0;
    endcase
  end

  always_comb begin
    take_skip = 1'b0;
    case (dec.sk)
      SK_ZERO:    take_skip = res_zero;
      SK_NONZERO: take_skip = !res_zero;
      SK_MEM_BIT: take_skip = mem_rdata[dec.bit_sel];
      default:    take_skip = 1'b0;
    endcase
  end

  assign pc_seq = take_skip ? pc_reg + 14'h0002 : pc_reg + 14'h0001;

  always_comb begin
    pc_exec = pc_seq;
    if (take_branch) begin
      if (dec.br == BR_JUMP) begin
        pc_exec = {bank_reg, instr_reg[10:0]};
      end else begin
        pc_exec = {pc_reg[13:`BANK_SHIFT], instr_reg[10:0]};
      end
    end
  end

  // Bus write to the pointer wins over an execute in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_reg <= `RST_POINTER;
    end else if (ce_i) begin
      if (bus_wr && bus_idx == `OFF_POINTER) begin
        pc_reg <= wb_dat_i[13:0];
      end else if (exec) begin
        pc_reg <= pc_exec;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg   <= `RST_RESULT;
      flags_reg <= '0;
    end else if (ce_i) begin
      if (bus_wr && bus_idx == `OFF_RESULT && wb_sel_i[0]) begin
        acc_reg             <= wb_dat_i[3:0];
        flags_reg.carry_bit <= wb_dat_i[`STAT_CARRY_BIT];
        flags_reg.zero_bit  <= wb_dat_i[`STAT_ZERO_BIT];
      end else if (exec) begin
        if (dec.wr_acc) begin
          acc_reg <= alu_res;
        end
        if (dec.upd_cf) begin
          flags_reg.carry_bit <= alu_cout;
        end
        if (dec.upd_zf) begin
          flags_reg.zero_bit <= res_zero;
        end
      end
    end
  end

  // Control: code bank, scratch page, run enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_reg <= `RST_BANK;
      page_reg <= `RST_PAGE;
      run_reg  <= `RST_RUN;
    end else if (ce_i && bus_wr && bus_idx == `OFF_CTRL) begin
      if (wb_sel_i[0]) begin
        bank_reg <= wb_dat_i[`CTRL_BANK_LSB +: 3];
        page_reg <= wb_dat_i[`CTRL_PAGE_LSB +: 3];
      end
      if (wb_sel_i[1]) begin
        run_reg <= wb_dat_i[`CTRL_RUN_BIT];
      end
    end
  end

  // Classic slave: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg  <= bus_req && !ack_reg;
      rdat_reg <= 32'h0000_0000;
      if (bus_req && !ack_reg && !wb_we_i) begin
        case (bus_idx)
          `OFF_CTRL: begin
            rdat_reg[`CTRL_BANK_LSB +: 3] <= bank_reg;
            rdat_reg[`CTRL_PAGE_LSB +: 3] <= page_reg;
            rdat_reg[`CTRL_RUN_BIT]       <= run_reg;
          end
          `OFF_STATUS: begin
            rdat_reg[3:0]                  <= acc_reg;
            rdat_reg[`STAT_CARRY_BIT]      <= flags_reg.carry_bit;
            rdat_reg[`STAT_ZERO_BIT]       <= flags_reg.zero_bit;
            rdat_reg[`STAT_BUSY_BIT]       <= (phase_reg != PH_FETCH);
            rdat_reg[`STAT_PTR_LSB +: 14]  <= pc_reg;
          end
          `OFF_POINTER: rdat_reg[13:0] <= pc_reg;
          `OFF_RESULT: begin
            rdat_reg[3:0]             <= acc_reg;
            rdat_reg[`STAT_CARRY_BIT] <= flags_reg.carry_bit;
            rdat_reg[`STAT_ZERO_BIT]  <= flags_reg.zero_bit;
          end
          default: rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign instr_ready_o = ready_reg;
  assign done_o        = done_reg;
  assign pc_o          = pc_reg;
  assign acc_o         = acc_reg;
  assign flags_o       = flags_reg;
  assign wb_dat_o      = rdat_reg;
  assign wb_ack_o      = ack_reg;

endmodule

// File: nibble_data_mem.sv
// Nibble-wide data memory with one write port and a registered read port
module nibble_data_mem #(
  parameter int AW = 7,
  parameter int DW = 4
) (
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i
);
  import nibble_exec_pkg::*;

  localparam int DEPTH = 1 << AW;

  if (AW < 7 || DW != 4) begin : g_check
    $error("nibble_data_mem needs AW >= 7 and DW == 4");
  end

  // No reset: contents are undefined until an executed instruction writes them
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// File: nibble_exec_chk_sva.sv
// Port checker for the nibble execute block
module nibble_exec_chk #(
  parameter int AW = 7
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic [15:0]             instr_i,
  input wire logic                    instr_valid_i,
  input wire logic                    instr_ready_o,
  input wire logic                    done_o,
  input wire logic [13:0]             pc_o,
  input wire logic [3:0]              acc_o,
  input wire nibble_exec_pkg::flags_t flags_o,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_ack_o,
  input wire logic [31:0]             wb_dat_o
);
  import nibble_exec_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence take_s;
    ce_i && instr_valid_i && instr_ready_o;
  endsequence
  a_ack_next: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o && wb_dat_o == 32'h0) else $error("ack held");
  a_ready_gap: assert property (take_s |=> !instr_ready_o [*3] ##1 instr_ready_o)
    else $error("ready gap wrong");
  a_done_after: assert property (take_s |-> ##3 done_o ##1 !done_o) else $error("done late");
  a_done_cause: assert property ($rose(done_o) |-> $past(instr_valid_i && instr_ready_o, 3))
    else $error("done without take");
  a_state_cause: assert property ($changed({pc_o, acc_o, flags_o}) |->
    $past(instr_valid_i && instr_ready_o, 3) || $past(wb_ack_o) || $past(rst_i)) else $error("stray update");
  a_branch_flags: assert property (take_s ##0 instr_i[15] |-> ##3 $stable({acc_o, flags_o}))
    else $error("flags moved");
  a_jump_low: assert property (take_s ##0 instr_i[15:11] == 5'h0e |->
    ##3 pc_o[10:0] == $past(instr_i[10:0], 3)) else $error("jump target");
  // A run-bit write lands at the ack edge, ready follows one edge later
  a_ready_fall: assert property ($fell(instr_ready_o) |->
    $past(instr_valid_i) || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("ready fell");
endmodule

bind nibble_alu_branch_exec nibble_exec_chk #(.AW(AW)) u_nibble_exec_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
  .done_o(done_o), .pc_o(pc_o), .acc_o(acc_o), .flags_o(flags_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));

// File: nibble_exec_defs.svh
// Offsets, field positions, reset values and timing for the nibble execute block
// Summary of operation
// - ADC memory: result gets mem+result+carry, flags
// - ADC memory writeback: sum to result and memory
// - ADC immediate: scratch+constant+carry into result only
// - ADC immediate writeback: sum to result and scratch
// - SUBTRACT_BORROW memory: mem-result-carry into result, flags
// - SUBTRACT_BORROW immediate writeback: scratch-constant-carry to both
// - OR memory: into result, zero bit only
// - OR memory writeback: result and memory nibble
// - Result-bit branches replace low eleven pointer bits
// - Branch if zero: result equals zero
// - Branch if nonzero: result not zero
// - Branch if carry bit is one
// - Branch if carry bit is not one
// - Decrement, write back, skip two if nonzero (bit 7 set) or if zero (bit 7 clear)
// - Memory bit skip, no flag change
// - Paged address is page times 10H plus offset
`ifndef NIBBLE_EXEC_DEFS_SVH
`define NIBBLE_EXEC_DEFS_SVH

`define OFF_CTRL        6'h00
`define OFF_STATUS      6'h01
`define OFF_POINTER     6'h02
`define OFF_RESULT      6'h03

`define CTRL_BANK_LSB   0
`define CTRL_PAGE_LSB   4
`define CTRL_RUN_BIT    8

`define STAT_CARRY_BIT  4
`define STAT_ZERO_BIT   5
`define STAT_BUSY_BIT   8
`define STAT_PTR_LSB    16

`define RST_BANK        3'h0
`define RST_PAGE        3'h0
`define RST_RUN         1'b1
`define RST_POINTER     14'h0000
`define RST_RESULT      4'h0

`define PAGE_SHIFT      4
`define BANK_SHIFT      11
`define PERIODS_PER_MC  4

`endif

// File: nibble_exec_pkg.sv
// Types shared by the nibble execute block
package nibble_exec_pkg;

  typedef enum logic [2:0] {
    ALU_PASS,
    ALU_ADD,
    ALU_SUB,
    ALU_OR,
    ALU_DEC
  } alu_op_t;

  typedef enum logic [2:0] {
    BR_NONE,
    BR_JUMP,
    BR_ACC_BIT,
    BR_ZERO,
    BR_NONZERO,
    BR_CARRY,
    BR_NO_CARRY
  } branch_t;

  typedef enum logic [1:0] {
    SK_NONE,
    SK_ZERO,
    SK_NONZERO,
    SK_MEM_BIT
  } skip_t;

  typedef enum logic [1:0] {
    PH_FETCH,
    PH_READ,
    PH_EXEC,
    PH_SETTLE
  } phase_t;

  typedef struct packed {
    alu_op_t    op;
    logic       use_imm;
    logic       use_cin;
    logic       wr_acc;
    logic       wr_mem;
    logic       upd_cf;
    logic       upd_zf;
    branch_t    br;
    skip_t      sk;
    logic [1:0] bit_sel;
  } decode_t;

  typedef struct packed {
    logic zero_bit;
    logic carry_bit;
  } flags_t;

endpackage

// File: tb.sv
// Self-checking bench for the nibble execute block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nibble_exec_pkg::*;
  logic        clk_i         = 1'b0;
  logic        rst_i         = 1'b1;
  logic        ce_i          = 1'b1;
  logic [15:0] instr_i       = 16'h0;
  logic        instr_valid_i = 1'b0;
  logic        wb_cyc_i      = 1'b0;
  logic        wb_stb_i      = 1'b0;
  logic        wb_we_i       = 1'b0;
  logic [7:0]  wb_adr_i      = 8'h0;
  logic [3:0]  wb_sel_i      = 4'hf;
  logic [31:0] wb_dat_i      = 32'h0;
  logic        instr_ready_o;
  logic        done_o;
  logic [13:0] pc_o;
  logic [3:0]  acc_o;
  flags_t      flags_o;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [13:0] pc            = 14'h0;
  int          err_total     = 0;
  int          comparisons   = 0;

  nibble_alu_branch_exec #(.AW(7)) u_nibble_alu_branch_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
    .pc_o(pc_o), .acc_o(acc_o), .flags_o(flags_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang();
    err_total++;
    $display("Error at %0t: no answer", $time);
    conclude();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic put(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb(1'b1, adr, dat, rd);
  endtask

  // Result register write also sets both flags
  task automatic st(input logic [3:0] a, input logic c, input logic z);
    put(8'h0c, {26'h0, z, c, a});
  endtask

  task automatic run(input logic [15:0] w, input logic [3:0] ea, input logic [1:0] ef, input logic [13:0] ep);
    int n;
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) hang();
    instr_i       <= w;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 20);
    if (n >= 20) hang();
    // Done is seen three edges after the take edge
    check(32'(n), 32'd3);
    check(acc_o, ea);
    check(flags_o, ef);
    check(pc_o, ep);
    pc = ep;
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    wb(1'b0, 8'h00, 32'h0, rd);
    check(rd, 32'h100);
    wb(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    put(8'h40, 32'hffff_ffff);
    put(8'h00, 32'h125);
    wb(1'b0, 8'h00, 32'h0, rd);
    check(rd, 32'h125);
  endtask

  // Memory is not reset, so seed nibble 25h by OR with all ones
  task automatic t_alu();
    st(4'h0, 1'b0, 1'b0);
    run(16'h3ff5, 4'hf, 2'b00, pc + 14'd1);
    st(4'h1, 1'b1, 1'b0);
    run(16'h0825, 4'h1, 2'b01, pc + 14'd1);
    st(4'h2, 1'b0, 1'b0);
    run(16'h0925, 4'h1, 2'b01, pc + 14'd1);
    st(4'h0, 1'b0, 1'b0);
    run(16'h0825, 4'h1, 2'b00, pc + 14'd1);
    st(4'h9, 1'b1, 1'b0);
    run(16'h0c35, 4'h5, 2'b00, pc + 14'd1);
    run(16'h0d25, 4'h3, 2'b00, pc + 14'd1);
    st(4'h4, 1'b0, 1'b0);
    run(16'h0a25, 4'hf, 2'b01, pc + 14'd1);
    run(16'h0f15, 4'h1, 2'b00, pc + 14'd1);
    st(4'h8, 1'b1, 1'b0);
    run(16'h3a25, 4'h9, 2'b01, pc + 14'd1);
    st(4'h2, 1'b1, 1'b1);
    run(16'h3b25, 4'h3, 2'b01, pc + 14'd1);
    st(4'h0, 1'b0, 1'b0);
    run(16'h0825, 4'h3, 2'b00, pc + 14'd1);
    // Leaves the nibble at 3 again for the decrement scenario
    run(16'h0e15, 4'h2, 2'b00, pc + 14'd1);
    run(16'h3e45, 4'h7, 2'b00, pc + 14'd1);
    st(4'h1, 1'b0, 1'b0);
    run(16'h0b25, 4'h2, 2'b00, pc + 14'd1);
    run(16'h0d15, 4'h3, 2'b00, pc + 14'd1);
  endtask

  // Run bit low, then clock enable low: an offered word must wait
  task automatic t_hold();
    logic [31:0] rd;
    wb(1'b0, 8'h04, 32'h0, rd);
    check(rd, {2'b00, pc, 16'h0036});
    put(8'h00, 32'h025);
    repeat (2) @(posedge clk_i);
    check(instr_ready_o, 1'b0);
    instr_i       <= 16'h7000;
    instr_valid_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({done_o, pc_o}, {1'b0, pc});
    instr_valid_i <= 1'b0;
    put(8'h00, 32'h125);
    @(posedge clk_i);
    ce_i          <= 1'b0;
    instr_valid_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({instr_ready_o, done_o, pc_o}, {2'b10, pc});
    ce_i          <= 1'b1;
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(pc_o, pc);
  endtask

  task automatic t_dec();
    run(16'h48a5, 4'h2, 2'b00, pc + 14'd2);
    run(16'h4825, 4'h1, 2'b00, pc + 14'd1);
    run(16'h48a5, 4'h0, 2'b10, pc + 14'd1);
    run(16'h3f15, 4'h1, 2'b00, pc + 14'd1);
    run(16'h4825, 4'h0, 2'b10, pc + 14'd2);
    run(16'h4825, 4'hf, 2'b01, pc + 14'd1);
  endtask

  task automatic t_skip();
    st(4'h6, 1'b1, 1'b1);
    for (int b = 0; b < 4; b++) begin
      run({7'h54, 2'(b), 7'h25}, 4'h6, 2'b11, pc + 14'd2);
    end
    run(16'h4825, 4'he, 2'b00, pc + 14'd1);
    st(4'h6, 1'b1, 1'b1);
    run(16'ha825, 4'h6, 2'b11, pc + 14'd1);
    run(16'ha8a5, 4'h6, 2'b11, pc + 14'd2);
  endtask

  // Pointer starts in bank 3 so the kept upper bits are visible
  task automatic br(input logic [3:0] op, input logic [3:0] a, input logic c, input logic tk);
    put(8'h08, 32'h1805);
    pc = 14'h1805;
    st(a, c, a == 4'h0);
    run({op, 1'b0, 11'h123}, a, {a == 4'h0, c}, tk ? 14'h1923 : 14'h1806);
  endtask

  task automatic t_branch();
    for (int b = 0; b < 4; b++) begin
      br(4'(8 + b), 4'(1 << b), 1'b0, 1'b1);
      br(4'(8 + b), ~4'(1 << b), 1'b1, 1'b0);
    end
    br(4'he, 4'h0, 1'b1, 1'b1);
    br(4'he, 4'h8, 1'b0, 1'b0);
    br(4'hc, 4'h4, 1'b0, 1'b1);
    br(4'hc, 4'h0, 1'b1, 1'b0);
    br(4'hf, 4'h2, 1'b1, 1'b1);
    br(4'hf, 4'h2, 1'b0, 1'b0);
    br(4'hd, 4'h2, 1'b0, 1'b1);
    br(4'hd, 4'h2, 1'b1, 1'b0);
    put(8'h08, 32'h5);
    run(16'h7123, 4'h2, 2'b01, 14'h2923);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_alu();
    t_dec();
    t_skip();
    t_hold();
    t_branch();
    conclude();
  end
endmodule
